/* rtl/host_port_device.sv */
// device end of the parallel host port, with the receive FIFO it feeds
// assumes host pins are asynchronous and held stable around each strobe
// Contract
// - data lines are a three-state bidirectional bus
// - host drives register select, device decodes it
// - port selected when either select is active
// - single-strobe mode takes direction from dir input
// - single-strobe mode times access by one strobe
// - double-strobe mode reads on read strobe
// - double-strobe mode writes on write strobe
// - strobe active level is programmable
// - single request output with programmable polarity
// - single request output driven or open-drain
// - double mode adds transmit request output
// - transmit request driven/open-drain, programmable polarity
`timescale 1ns/1ps
`default_nettype none

// small synchronous FIFO with honest full and empty
module sync_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // filling side
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    // draining side
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    logic [WIDTH-1:0] mem_reg [DEPTH]; // storage words
    logic [PW-1:0] wptr_reg, wptr_next; // write slot
    logic [PW-1:0] rptr_reg, rptr_next; // read slot
    logic [CW-1:0] count_reg, count_next; // words held
    logic push, pop;

    // pointer and occupancy update
    always_comb begin
        push = in_valid_i && in_ready_o;
        pop = out_valid_o && out_ready_i;
        wptr_next = wptr_reg;
        rptr_next = rptr_reg;
        count_next = count_reg;
        if (push) begin
            wptr_next = (wptr_reg == PW'(DEPTH - 1)) ? '0 : PW'(wptr_reg + 1'b1);
        end
        if (pop) begin
            rptr_next = (rptr_reg == PW'(DEPTH - 1)) ? '0 : PW'(rptr_reg + 1'b1);
        end
        if (push && !pop) begin
            count_next = CW'(count_reg + 1'b1);
        end else if (pop && !push) begin
            count_next = CW'(count_reg - 1'b1);
        end
    end

    // registers; storage has no reset, it is qualified by count
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            count_reg <= '0;
        end else begin
            wptr_reg <= wptr_next;
            rptr_reg <= rptr_next;
            count_reg <= count_next;
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_reg[wptr_reg] <= in_data_i;
        end
    end

    assign in_ready_o = (count_reg != CW'(DEPTH));
    assign out_valid_o = (count_reg != '0);
    assign out_data_o = mem_reg[rptr_reg];
endmodule : sync_fifo

module host_port_device (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // pins toward the host
    host_port_if.device link,
    // configuration
    input wire host_port_pkg::strobe_mode_t strobe_mode_i,
    input wire logic strobe_high_i,
    input wire host_port_pkg::req_mode_t req_mode_i,
    input wire logic req_high_i,
    input wire logic req_open_drain_i,
    // words written by the host
    output logic [15:0] rx_data_o,
    output logic rx_valid_o,
    input wire logic rx_ready_i,
    // word offered to the host
    input wire logic [15:0] tx_data_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o
);
    import host_port_pkg::*;

    logic [PIN_W-1:0] raw_pins; // pin vector before sync
    logic [PIN_W-1:0] s1_reg, s2_reg, s3_reg; // synchroniser stages
    logic [PIN_W-1:0] filt_reg, filt_next; // agreed pin levels
    logic sel, rd_act, wr_act; // decoded access state
    logic rd_prev_reg, rd_prev_next; // read phase one cycle ago
    logic wr_prev_reg, wr_prev_next; // write phase one cycle ago
    logic [3:0] rd_addr_reg, rd_addr_next; // register under read
    logic [15:0] dout_reg, dout_next; // read data on the pins
    logic doe_reg, doe_next; // data line enable
    logic [15:0] tx_hold_reg, tx_hold_next; // word waiting for host
    logic tx_full_reg, tx_full_next; // tx word valid
    logic tx_ready_reg, tx_ready_next; // registered free flag, so the user output comes from a flop
    logic sreq_reg, sreq_next, sreq_oe_reg, sreq_oe_next; // service request pin
    logic treq_reg, treq_next, treq_oe_reg, treq_oe_next; // transmit request pin
    logic fifo_push, fifo_ready, fifo_valid; // receive FIFO handshake
    logic [15:0] fifo_data;
    logic tx_pop, tx_load, need_s, need_t, lvl_s, lvl_t;
    logic [15:0] status_word;

    assign raw_pins = {link.write_strobe_in, link.read_strobe_in, link.single_strobe_in,
                       link.access_direction_in, link.port_select_b, link.port_select_a,
                       link.host_register_select, link.host_data_lines};

    // three-stage synchroniser; only s2 and s3 feed the filter
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= raw_pins;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // access decode and pin drive
    always_comb begin
        filt_next = PIN_W'(filt_update(32'(s2_reg), 32'(s3_reg), 32'(filt_reg)));
        sel = filt_reg[PIN_SEL_A] | filt_reg[PIN_SEL_B];
        if (strobe_mode_i == STROBE_SINGLE) begin
            // one strobe, direction from the dir input; high means read
            rd_act = sel && pol_map(filt_reg[PIN_DS], strobe_high_i) && filt_reg[PIN_DIR];
            wr_act = sel && pol_map(filt_reg[PIN_DS], strobe_high_i) && !filt_reg[PIN_DIR];
        end else begin
            // separate strobes; both asserted at once counts as neither
            rd_act = sel && pol_map(filt_reg[PIN_RD], strobe_high_i)
                && !pol_map(filt_reg[PIN_WR], strobe_high_i);
            wr_act = sel && pol_map(filt_reg[PIN_WR], strobe_high_i)
                && !pol_map(filt_reg[PIN_RD], strobe_high_i);
        end
        rd_prev_next = rd_act;
        wr_prev_next = wr_act;
        status_word = '0;
        status_word[STAT_TX_FULL_BIT] = tx_full_reg;
        status_word[STAT_RX_SPACE_BIT] = fifo_ready;
        status_word[STAT_RX_EMPTY_BIT] = !fifo_valid;
        rd_addr_next = rd_addr_reg;
        dout_next = dout_reg;
        if (rd_act && !rd_prev_reg) begin
            // snapshot at read start so the word stays steady for the host
            rd_addr_next = filt_reg[PIN_ADDR_LSB +: 4];
            if (filt_reg[PIN_ADDR_LSB +: 4] == REG_STATUS) begin
                dout_next = status_word;
            end else if (filt_reg[PIN_ADDR_LSB +: 4] == REG_DATA) begin
                dout_next = tx_hold_reg;
            end else begin
                dout_next = DATA_RESET; // unmapped reads return zero
            end
        end
        doe_next = rd_act;
        // write completes on strobe release; data still held by host
        fifo_push = !wr_act && wr_prev_reg && (filt_reg[PIN_ADDR_LSB +: 4] == REG_DATA);
        // the tx word is consumed when a data read ends
        tx_pop = !rd_act && rd_prev_reg && (rd_addr_reg == REG_DATA) && tx_full_reg;
        tx_load = tx_valid_i && !tx_full_reg;
        tx_full_next = tx_load || (tx_full_reg && !tx_pop);
        tx_hold_next = tx_load ? tx_data_i : tx_hold_reg;
        tx_ready_next = !tx_full_next;
        // request needs: single line covers both directions
        if (req_mode_i == REQ_SINGLE) begin
            need_s = tx_full_reg || fifo_ready;
            need_t = 1'b0;
        end else begin
            need_s = fifo_ready;
            need_t = tx_full_reg;
        end
        lvl_s = pol_map(need_s, req_high_i);
        lvl_t = pol_map(need_t, req_high_i);
        // open-drain only pulls low, pull-up gives the high level
        sreq_next = req_open_drain_i ? 1'b0 : lvl_s;
        sreq_oe_next = req_open_drain_i ? !lvl_s : 1'b1;
        treq_next = req_open_drain_i ? 1'b0 : lvl_t;
        treq_oe_next = (req_mode_i == REQ_DOUBLE) && (req_open_drain_i ? !lvl_t : 1'b1);
    end

    // state registers
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            filt_reg <= '0;
            rd_prev_reg <= 1'b0;
            wr_prev_reg <= 1'b0;
            rd_addr_reg <= '0;
            dout_reg <= DATA_RESET;
            doe_reg <= 1'b0;
            tx_hold_reg <= DATA_RESET;
            tx_full_reg <= 1'b0;
            tx_ready_reg <= 1'b1;
            sreq_reg <= 1'b0;
            sreq_oe_reg <= 1'b0;
            treq_reg <= 1'b0;
            treq_oe_reg <= 1'b0;
        end else begin
            filt_reg <= filt_next;
            rd_prev_reg <= rd_prev_next;
            wr_prev_reg <= wr_prev_next;
            rd_addr_reg <= rd_addr_next;
            dout_reg <= dout_next;
            doe_reg <= doe_next;
            tx_hold_reg <= tx_hold_next;
            tx_full_reg <= tx_full_next;
            tx_ready_reg <= tx_ready_next;
            sreq_reg <= sreq_next;
            sreq_oe_reg <= sreq_oe_next;
            treq_reg <= treq_next;
            treq_oe_reg <= treq_oe_next;
        end
    end

    // host writes land here; a write while full is dropped, status shows it
    sync_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) rx_fifo (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .in_data_i(filt_reg[PIN_DATA_LSB +: 16]),
        .in_valid_i(fifo_push),
        .in_ready_o(fifo_ready),
        .out_data_o(fifo_data),
        .out_valid_o(fifo_valid),
        .out_ready_i(rx_ready_i)
    );

    assign rx_data_o = fifo_data;
    assign rx_valid_o = fifo_valid;
    assign tx_ready_o = tx_ready_reg;
    assign link.d2h_data = dout_reg;
    assign link.d2h_oe = doe_reg;
    assign link.service_request_out = sreq_reg;
    assign link.service_request_oe = sreq_oe_reg;
    assign link.transmit_request_out = treq_reg;
    assign link.transmit_request_oe = treq_oe_reg;
endmodule : host_port_device
`default_nettype wire

/* rtl/host_port_host.sv */
// host end of the parallel host port: turns user commands into pin cycles
// assumes the device synchronises pins and answers within the strobe window
`timescale 1ns/1ps
`default_nettype none
module host_port_host (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // pins toward the device
    host_port_if.host link,
    // configuration, must match the device
    input wire host_port_pkg::strobe_mode_t strobe_mode_i,
    input wire logic strobe_high_i,
    input wire logic req_high_i,
    input wire logic use_select_b_i,
    // command side
    input wire logic cmd_valid_i,
    input wire logic cmd_write_i,
    input wire logic [3:0] cmd_addr_i,
    input wire logic [15:0] cmd_wdata_i,
    output logic cmd_ready_o,
    // answer side
    output logic rsp_valid_o,
    output logic [15:0] rsp_data_o,
    // request lines, active high after polarity
    output logic service_req_o,
    output logic transmit_req_o
);
    import host_port_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SETUP = 2'b01,
        ST_STROBE = 2'b10,
        ST_HOLD = 2'b11
    } host_state_t;

    logic [HPIN_W-1:0] raw_pins, s1_reg, s2_reg, s3_reg; // synchroniser stages
    logic [HPIN_W-1:0] filt_reg, filt_next; // agreed levels
    host_state_t state_reg, state_next; // access phase
    logic [3:0] cnt_reg, cnt_next; // phase cycle count
    logic wr_reg, wr_next; // access is a write
    logic [3:0] addr_reg, addr_next;
    logic [15:0] wdata_reg, wdata_next;
    logic sel_reg, sel_next; // select asserted
    logic stb_reg, stb_next; // strobe active
    logic oe_reg, oe_next; // host drives data
    logic ready_reg, ready_next;
    logic rsp_v_reg, rsp_v_next;
    logic [15:0] rsp_d_reg, rsp_d_next;
    logic sreq_reg, sreq_next, treq_reg, treq_next;

    assign raw_pins = {link.transmit_request_wire, link.service_request_wire, link.host_data_lines};

    // three-stage synchroniser on everything coming from the device
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= raw_pins;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // access sequencer: setup, strobe, hold; counts are fixed
    always_comb begin
        filt_next = HPIN_W'(filt_update(32'(s2_reg), 32'(s3_reg), 32'(filt_reg)));
        sreq_next = pol_map(filt_reg[HPIN_SREQ], req_high_i);
        treq_next = pol_map(filt_reg[HPIN_TREQ], req_high_i);
        state_next = state_reg;
        cnt_next = cnt_reg;
        wr_next = wr_reg;
        addr_next = addr_reg;
        wdata_next = wdata_reg;
        sel_next = sel_reg;
        stb_next = stb_reg;
        oe_next = oe_reg;
        ready_next = ready_reg;
        rsp_v_next = 1'b0;
        rsp_d_next = rsp_d_reg;
        case (state_reg)
            ST_IDLE: begin
                if (cmd_valid_i && ready_reg) begin
                    // present address, select and direction first
                    wr_next = cmd_write_i;
                    addr_next = cmd_addr_i;
                    wdata_next = cmd_wdata_i;
                    sel_next = 1'b1;
                    oe_next = cmd_write_i;
                    ready_next = 1'b0;
                    cnt_next = SETUP_CYCLES;
                    state_next = ST_SETUP;
                end
            end
            ST_SETUP: begin
                if (cnt_reg == 4'h1) begin
                    stb_next = 1'b1;
                    cnt_next = STROBE_CYCLES;
                    state_next = ST_STROBE;
                end else begin
                    cnt_next = cnt_reg - 4'h1;
                end
            end
            ST_STROBE: begin
                if (cnt_reg == 4'h1) begin
                    // sample read data just before releasing the strobe
                    rsp_v_next = !wr_reg;
                    rsp_d_next = wr_reg ? rsp_d_reg : filt_reg[15:0];
                    stb_next = 1'b0;
                    cnt_next = HOLD_CYCLES;
                    state_next = ST_HOLD;
                end else begin
                    cnt_next = cnt_reg - 4'h1;
                end
            end
            ST_HOLD: begin
                // keep address and data until the device has seen the release
                if (cnt_reg == 4'h1) begin
                    sel_next = 1'b0;
                    oe_next = 1'b0;
                    ready_next = 1'b1;
                    state_next = ST_IDLE;
                end else begin
                    cnt_next = cnt_reg - 4'h1;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // state registers
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            filt_reg <= '0;
            state_reg <= ST_IDLE;
            cnt_reg <= '0;
            wr_reg <= 1'b0;
            addr_reg <= '0;
            wdata_reg <= DATA_RESET;
            sel_reg <= 1'b0;
            stb_reg <= 1'b0;
            oe_reg <= 1'b0;
            ready_reg <= 1'b1;
            rsp_v_reg <= 1'b0;
            rsp_d_reg <= DATA_RESET;
            sreq_reg <= 1'b0;
            treq_reg <= 1'b0;
        end else begin
            filt_reg <= filt_next;
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            wr_reg <= wr_next;
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
            sel_reg <= sel_next;
            stb_reg <= stb_next;
            oe_reg <= oe_next;
            ready_reg <= ready_next;
            rsp_v_reg <= rsp_v_next;
            rsp_d_reg <= rsp_d_next;
            sreq_reg <= sreq_next;
            treq_reg <= treq_next;
        end
    end

    // pin levels follow strobe polarity; unused strobes sit inactive
    assign link.h2d_data = wdata_reg;
    assign link.h2d_oe = oe_reg;
    assign link.host_register_select = addr_reg;
    assign link.port_select_a = sel_reg && !use_select_b_i;
    assign link.port_select_b = sel_reg && use_select_b_i;
    assign link.access_direction_in = !wr_reg;
    assign link.single_strobe_in = pol_map(stb_reg && (strobe_mode_i == STROBE_SINGLE), strobe_high_i);
    assign link.read_strobe_in = pol_map(stb_reg && !wr_reg && (strobe_mode_i == STROBE_DOUBLE), strobe_high_i);
    assign link.write_strobe_in = pol_map(stb_reg && wr_reg && (strobe_mode_i == STROBE_DOUBLE), strobe_high_i);
    assign cmd_ready_o = ready_reg;
    assign rsp_valid_o = rsp_v_reg;
    assign rsp_data_o = rsp_d_reg;
    assign service_req_o = sreq_reg;
    assign transmit_req_o = treq_reg;
endmodule : host_port_host
`default_nettype wire

/* rtl/host_port_if.sv */
// pin bundle joining the host end and the device end of the parallel host port
// assumes nothing beyond the two modports; resolves shared and open-drain wires here
`timescale 1ns/1ps
`default_nettype none
interface host_port_if;
    // host-driven pins
    logic [15:0] h2d_data;
    logic h2d_oe;
    logic [3:0] host_register_select;
    logic port_select_a;
    logic port_select_b;
    logic access_direction_in;
    logic single_strobe_in;
    logic read_strobe_in;
    logic write_strobe_in;
    // device-driven pins
    logic [15:0] d2h_data;
    logic d2h_oe;
    logic service_request_out;
    logic service_request_oe;
    logic transmit_request_out;
    logic transmit_request_oe;
    // resolved wire levels; undriven lines float high through pull-ups
    logic [15:0] host_data_lines;
    logic service_request_wire;
    logic transmit_request_wire;
    assign host_data_lines = d2h_oe ? d2h_data : (h2d_oe ? h2d_data : 16'hFFFF);
    assign service_request_wire = service_request_oe ? service_request_out : 1'b1;
    assign transmit_request_wire = transmit_request_oe ? transmit_request_out : 1'b1;

    modport device (
        input host_data_lines, host_register_select, port_select_a, port_select_b,
        input access_direction_in, single_strobe_in, read_strobe_in, write_strobe_in,
        output d2h_data, d2h_oe, service_request_out, service_request_oe,
        output transmit_request_out, transmit_request_oe
    );
    modport host (
        input host_data_lines, service_request_wire, transmit_request_wire,
        output h2d_data, h2d_oe, host_register_select, port_select_a, port_select_b,
        output access_direction_in, single_strobe_in, read_strobe_in, write_strobe_in
    );
endinterface : host_port_if
`default_nettype wire

/* rtl/host_port_pkg.sv */
// shared constants, types and helpers for the 16-bit parallel host port
// assumes both ends run on one clock and pins cross through 3-flop synchronisers
package host_port_pkg;
    // bus widths
    localparam int DATA_W = 16;
    localparam int ADDR_W = 4;
    // host register map, selected by host_register_select
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_DATA = 4'h1;
    // status register bit positions
    localparam int STAT_TX_FULL_BIT = 0;
    localparam int STAT_RX_SPACE_BIT = 1;
    localparam int STAT_RX_EMPTY_BIT = 2;
    // reset values
    localparam logic [15:0] DATA_RESET = 16'h0000;
    // device-side pin vector layout
    localparam int PIN_DATA_LSB = 0;
    localparam int PIN_ADDR_LSB = 16;
    localparam int PIN_SEL_A = 20;
    localparam int PIN_SEL_B = 21;
    localparam int PIN_DIR = 22;
    localparam int PIN_DS = 23;
    localparam int PIN_RD = 24;
    localparam int PIN_WR = 25;
    localparam int PIN_W = 26;
    // host-side pin vector layout
    localparam int HPIN_SREQ = 16;
    localparam int HPIN_TREQ = 17;
    localparam int HPIN_W = 18;
    // buffering and host access timing, in clock cycles
    localparam int FIFO_DEPTH = 4;
    localparam logic [3:0] SETUP_CYCLES = 4'h4;
    localparam logic [3:0] STROBE_CYCLES = 4'hC;
    localparam logic [3:0] HOLD_CYCLES = 4'h8;
    // access and request modes
    typedef enum logic {STROBE_SINGLE = 1'b0, STROBE_DOUBLE = 1'b1} strobe_mode_t;
    typedef enum logic {REQ_SINGLE = 1'b0, REQ_DOUBLE = 1'b1} req_mode_t;

    // a bit changes once the second and third synchroniser stages agree
    function automatic logic [31:0] filt_update(input logic [31:0] s2, input logic [31:0] s3,
                                                input logic [31:0] old);
        filt_update = (s2 & s3) | (old & (s2 ^ s3));
    endfunction : filt_update

    // pin level <-> active flag; polarity 1 means high-active (involution)
    function automatic logic pol_map(input logic lvl, input logic high_active);
        pol_map = lvl ~^ high_active;
    endfunction : pol_map
endpackage : host_port_pkg

/* testbench/host_port_checker.sv */
// pin-level checks on the link between host end and device end
// assumes one clock domain; instantiated beside the interface
`timescale 1ns/1ps
`default_nettype none
module host_port_checker (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // link pins
    input wire logic [15:0] d2h_data,
    input wire logic d2h_oe,
    input wire logic h2d_oe,
    input wire logic [3:0] host_register_select,
    input wire logic port_select_a,
    input wire logic port_select_b,
    input wire logic service_request_out,
    input wire logic service_request_oe,
    input wire logic transmit_request_out,
    input wire logic transmit_request_oe
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);
    // effective select, either input counts
    wire logic sel = port_select_a | port_select_b;
    // a read drive starts, then must last past the strobe filter
    sequence drive_start_s;
        $rose(d2h_oe);
    endsequence
    sequence drive_hold_s;
        d2h_oe [*5];
    endsequence
    no_clash_a: assert property (h2d_oe |-> !d2h_oe) else $error("both ends drive data");
    drive_sel_a: assert property (d2h_oe |-> sel) else $error("data driven unselected");
    drive_len_a: assert property (drive_start_s |-> drive_hold_s) else $error("read drive short");
    read_data_a: assert property (d2h_oe && $past(d2h_oe) |-> $stable(d2h_data)) else $error("read data moved");
    addr_hold_a: assert property (sel && $past(sel) |-> $stable(host_register_select)) else $error("index moved");
    wdata_sel_a: assert property (h2d_oe |-> sel) else $error("write data unselected");
    release_a: assert property ($fell(sel) |-> !d2h_oe) else $error("drive after deselect");
    sreq_od_a: assert property ($fell(service_request_oe) |-> !service_request_out) else $error("sreq bad");
    treq_od_a: assert property ($fell(transmit_request_oe) |-> !transmit_request_out) else $error("treq bad");
endmodule : host_port_checker
`default_nettype wire

/* testbench/testbench.sv */
// bench joining host end and device end, with a queue model of the port
// assumes design files compiled first; 25 MHz clock
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import host_port_pkg::*;
    logic clk_i = 0, resetn_i = 0, sh, rh, od, usb, cv, cw, tv, rr, txw;
    strobe_mode_t sm;
    req_mode_t rm;
    logic [3:0] ca;
    logic [15:0] cd, td, got, rd, rxd;
    logic [31:0] rnd;
    logic cr, rv, sr, tr, rxv, txr;
    logic [15:0] q[$];
    int failures = 0, n_checks = 0, seed = 42;
    host_port_if link_inst();
    host_port_device host_port_device_inst (.clk_i, .resetn_i, .link(link_inst), .strobe_mode_i(sm),
        .strobe_high_i(sh), .req_mode_i(rm), .req_high_i(rh), .req_open_drain_i(od), .rx_data_o(rxd),
        .rx_valid_o(rxv), .rx_ready_i(rr), .tx_data_i(td), .tx_valid_i(tv), .tx_ready_o(txr));
    host_port_host host_port_host_inst (.clk_i, .resetn_i, .link(link_inst), .strobe_mode_i(sm),
        .strobe_high_i(sh), .req_high_i(rh), .use_select_b_i(usb), .cmd_valid_i(cv), .cmd_write_i(cw),
        .cmd_addr_i(ca), .cmd_wdata_i(cd), .cmd_ready_o(cr), .rsp_valid_o(rv), .rsp_data_o(rd),
        .service_req_o(sr), .transmit_req_o(tr));
    host_port_checker host_port_checker_inst (.clk_i, .resetn_i, .d2h_data(link_inst.d2h_data),
        .d2h_oe(link_inst.d2h_oe), .h2d_oe(link_inst.h2d_oe),
        .host_register_select(link_inst.host_register_select), .port_select_a(link_inst.port_select_a),
        .port_select_b(link_inst.port_select_b), .service_request_out(link_inst.service_request_out),
        .service_request_oe(link_inst.service_request_oe), .transmit_request_out(link_inst.transmit_request_out),
        .transmit_request_oe(link_inst.transmit_request_oe));
    always #20 clk_i = ~clk_i;
    task chk(input string n, input logic [15:0] s, input logic [15:0] e);
        n_checks++;
        if (s !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task report_and_stop;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop
    // one host command; a read answer is caught while the port is busy
    task cmd(input logic w, input logic [3:0] a, input logic [15:0] d);
        int k;
        k = 0;
        while (cr !== 1'b1 && k < 60) begin
            @(negedge clk_i);
            k++;
        end
        cv = 1;
        cw = w;
        ca = a;
        cd = d;
        @(negedge clk_i);
        cv = 0;
        got = 16'hXXXX;
        k = 0;
        while (cr !== 1'b1 && k < 60) begin
            if (rv === 1'b1) got = rd;
            @(negedge clk_i);
            k++;
        end
        // a port that never comes back is a mismatch
        if (cr !== 1'b1) failures++;
    endtask : cmd
    // status and request lines against the model
    task stat_chk;
        logic sp;
        sp = q.size() < FIFO_DEPTH;
        repeat (8) @(negedge clk_i);
        chk("service req", 16'(sr), 16'(rm == REQ_DOUBLE ? sp : (sp | txw)));
        chk("tx ready", 16'(txr), 16'(!txw));
        if (rm == REQ_DOUBLE) chk("transmit req", 16'(tr), 16'(txw));
        cmd(0, REG_STATUS, 16'h0);
        chk("status", got, {13'h0, q.size() == 0, sp, txw});
    endtask : stat_chk
    initial begin
        {cv, cw, tv, rr, ca, cd, td} = '0;
        for (int i = 0; i < 4; i++) begin
            resetn_i = 0;
            rnd = $random(seed);
            sm = strobe_mode_t'(i[0]);
            sh = i[1];
            // request mode and drive style cover all four pairings over the rounds
            rm = req_mode_t'(i[0] ^ i[1]);
            rh = rnd[1];
            od = i[0];
            usb = rnd[3];
            repeat (16) @(negedge clk_i);
            resetn_i = 1;
            q.delete();
            td = rnd[31:16];
            tv = 1;
            @(negedge clk_i);
            tv = 0;
            txw = 1;
            stat_chk();
            cmd(0, REG_DATA, 16'h0);
            chk("tx word", got, td);
            txw = 0;
            cmd(0, 4'h5, 16'h0);
            chk("unmapped", got, 16'h0000);
            for (int j = 0; j < 5; j++) begin
                rnd = $random(seed);
                cmd(1, REG_DATA, rnd[15:0]);
                if (q.size() < FIFO_DEPTH) q.push_back(rnd[15:0]);
            end
            stat_chk();
            while (q.size() > 0) begin
                chk("rx valid", 16'(rxv), 16'h0001);
                chk("rx word", rxd, q.pop_front());
                rr = 1;
                @(negedge clk_i);
                rr = 0;
                @(negedge clk_i);
            end
            stat_chk();
        end
        report_and_stop();
    end
    // hang guard: the rounds need some 1200 cycles
    initial begin
        #(40 * 20000);
        failures++;
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
